/* src/psg_pkg.sv */
// constants of the power status group: command selects, bit positions, resets
// assumes one 50 MHz clock domain; nothing here is device-identity related
package psg_pkg;
  localparam int DW = 16;
  localparam int SELW = 3;
  // register and command selects on the command port
  localparam logic [2:0] SEL_COND = 3'h0;
  localparam logic [2:0] SEL_RISE = 3'h1;
  localparam logic [2:0] SEL_FALL = 3'h2;
  localparam logic [2:0] SEL_LATCH = 3'h3;
  localparam logic [2:0] SEL_MASK = 3'h4;
  localparam logic [2:0] SEL_PROT_CLEAR = 3'h5;
  // condition bit positions
  localparam int BIT_REV_TRIP = 0;
  localparam int BIT_UNLEVEL = 1;
  localparam int BIT_MOD_DRIVE = 2;
  localparam int BIT_LOWBAND = 3;
  localparam int NSRC = 4;
  // bit 15 never stores anything
  localparam logic [15:0] KEEP_BITS = 16'h7FFF;
  localparam logic [15:0] RST_RISE = 16'h7FFF;
  localparam logic [15:0] RST_FALL = 16'h0000;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [3:0] RST_SRC = 4'h0;
endpackage

/* src/psg_sync.sv */
// three-stage synchroniser with agreement filter for asynchronous fault pins
// assumes rst_n synchronous to clk; output changes once stages two and three agree
`timescale 1ns/1ps
module psg_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] q_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // s1_r is read by s2_r only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= psg_pkg::RST_SRC;
      s2_r <= psg_pkg::RST_SRC;
      s3_r <= psg_pkg::RST_SRC;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a disagreeing bit keeps its old value, so a single glitch never counts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r <= psg_pkg::RST_SRC;
    end else begin
      q_r <= (s2_r & ~(s2_r ^ s3_r)) | (q_r & (s2_r ^ s3_r));
    end
  end
endmodule // psg_sync

/* src/psg_event_bank.sv */
// sticky transition latch, one cell per bit
// assumes cond and prev are registered on the same clock
`timescale 1ns/1ps
module psg_event_bank (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] cond,
  input wire logic [15:0] prev,
  input wire logic [15:0] rise_en,
  input wire logic [15:0] fall_en,
  input wire logic clear,
  output logic [15:0] event_r
);
  genvar i;
  generate
    for (i = 0; i < psg_pkg::DW; i++) begin : g_cell
      logic hit;
      assign hit = (cond[i] & ~prev[i] & rise_en[i]) | (~cond[i] & prev[i] & fall_en[i]);
      // a new edge wins over the read-clear of the same cycle
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          event_r[i] <= 1'b0;
        end else begin
          event_r[i] <= hit | (event_r[i] & ~clear);
        end
      end
    end
  endgenerate
endmodule // psg_event_bank

/* src/psg_power_status.sv */
// power status group: live condition, transition filters, sticky latch, summary
// assumes fault pins are asynchronous; command port is synchronous to clk
`timescale 1ns/1ps

// Functional notes
// - bit 0 trips, cleared by protection clear
// - bit 1 follows unleveled loop report
// - bit 2 follows modulator drive excess flag
// - bit 3 follows lowband heater fault
// - bits 4 to 15 read zero
// - build options remove sources, reading zero
// - condition tracks live inputs, ignores writes
// - query returns binary weighted bit sum
// - enabled rising or falling edges set latch
// - latch bits hold until cleared
// - latch read returns and clears, unwritable
// - summary is any enabled latched bit
// - filters and mask read back last write, bit 15 zero
// - summary feeds parent power flag bit
module psg_power_status #(
  parameter bit HAS_REV_POWER = 1'b1,
  parameter bit HAS_MOD_DRIVE = 1'b1,
  parameter bit HAS_LOWBAND = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reverse_power_trip_in,
  input wire logic unleveled_in,
  input wire logic modulator_drive_excess_in,
  input wire logic lowband_heater_fault_in,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [2:0] cmd_sel,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid_r,
  output logic [15:0] rsp_data_r,
  output logic power_summary_r
);
  logic [3:0] src_pins;
  logic [3:0] src_q;
  logic [15:0] cond_r;
  logic [15:0] cond_nxt;
  logic [15:0] prev_r;
  logic [15:0] rise_r;
  logic [15:0] fall_r;
  logic [15:0] mask_r;
  logic [15:0] event_r;
  logic rd;
  logic wr;
  logic latch_rd;
  logic prot_clear;

  function automatic logic is_sel(input logic [2:0] sel, input logic [2:0] code);
    is_sel = (sel == code);
  endfunction

  assign src_pins = {lowband_heater_fault_in, modulator_drive_excess_in,
                     unleveled_in, reverse_power_trip_in};

  psg_sync #(.W(psg_pkg::NSRC)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(src_pins),
    .q_r(src_q)
  );

  assign rd = cmd_valid & ~cmd_write;
  assign wr = cmd_valid & cmd_write;
  assign latch_rd = rd & is_sel(cmd_sel, psg_pkg::SEL_LATCH);
  assign prot_clear = wr & is_sel(cmd_sel, psg_pkg::SEL_PROT_CLEAR);

  // condition has no write data path; only the protection clear write can drop bit 0
  always_comb begin
    cond_nxt = psg_pkg::RST_ZERO;
    // trip stays latched while the pin is low until protection is cleared
    cond_nxt[psg_pkg::BIT_REV_TRIP] = HAS_REV_POWER &
      (src_q[psg_pkg::BIT_REV_TRIP] |
       (cond_r[psg_pkg::BIT_REV_TRIP] & ~prot_clear));
    cond_nxt[psg_pkg::BIT_UNLEVEL] = src_q[psg_pkg::BIT_UNLEVEL];
    cond_nxt[psg_pkg::BIT_MOD_DRIVE] = HAS_MOD_DRIVE & src_q[psg_pkg::BIT_MOD_DRIVE];
    cond_nxt[psg_pkg::BIT_LOWBAND] = HAS_LOWBAND & src_q[psg_pkg::BIT_LOWBAND];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_r <= psg_pkg::RST_ZERO;
      prev_r <= psg_pkg::RST_ZERO;
    end else begin
      cond_r <= cond_nxt;
      prev_r <= cond_r;
    end
  end

  // filters and mask; software writes the weight sum of wanted bits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rise_r <= psg_pkg::RST_RISE;
    end else if (wr && is_sel(cmd_sel, psg_pkg::SEL_RISE)) begin
      rise_r <= cmd_wdata & psg_pkg::KEEP_BITS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fall_r <= psg_pkg::RST_FALL;
    end else if (wr && is_sel(cmd_sel, psg_pkg::SEL_FALL)) begin
      fall_r <= cmd_wdata & psg_pkg::KEEP_BITS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_r <= psg_pkg::RST_MASK;
    end else if (wr && is_sel(cmd_sel, psg_pkg::SEL_MASK)) begin
      mask_r <= cmd_wdata & psg_pkg::KEEP_BITS;
    end
  end

  // writes to the latch select fall through: it is read-clear only
  psg_event_bank u_events (
    .clk(clk),
    .rst_n(rst_n),
    .cond(cond_r),
    .prev(prev_r),
    .rise_en(rise_r),
    .fall_en(fall_r),
    .clear(latch_rd),
    .event_r(event_r)
  );

  // one cycle behind the latch, kept registered so the parent sees a clean level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power_summary_r <= 1'b0;
    end else begin
      power_summary_r <= |(event_r & mask_r);
    end
  end

  // query answer: the register word itself is the weighted sum
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= psg_pkg::RST_ZERO;
    end else begin
      rsp_valid_r <= rd;
      if (!rd) begin
        rsp_data_r <= psg_pkg::RST_ZERO;
      end else if (is_sel(cmd_sel, psg_pkg::SEL_COND)) begin
        rsp_data_r <= cond_r;
      end else if (is_sel(cmd_sel, psg_pkg::SEL_RISE)) begin
        rsp_data_r <= rise_r;
      end else if (is_sel(cmd_sel, psg_pkg::SEL_FALL)) begin
        rsp_data_r <= fall_r;
      end else if (latch_rd) begin
        rsp_data_r <= event_r;
      end else if (is_sel(cmd_sel, psg_pkg::SEL_MASK)) begin
        rsp_data_r <= mask_r;
      end else begin
        rsp_data_r <= psg_pkg::RST_ZERO;
      end
    end
  end

  // helper terms for the checks below
  logic [15:0] pos_hit;
  logic [15:0] neg_hit;
  logic [15:0] set_vec;
  logic mask_wr;
  logic [15:0] mask_wdata;
  assign pos_hit = cond_r & ~prev_r & rise_r;
  assign neg_hit = ~cond_r & prev_r & fall_r;
  assign set_vec = pos_hit | neg_hit;
  assign mask_wr = wr & is_sel(cmd_sel, psg_pkg::SEL_MASK);
  assign mask_wdata = cmd_wdata & psg_pkg::KEEP_BITS;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_trip_hold;
    cond_r[0] && !prot_clear |=> cond_r[0];
  endproperty
  a_trip_hold: assert property (p_trip_hold)
    else $error("trip bit dropped without clear");

  property p_trip_clear;
    prot_clear && !src_q[0] |=> !cond_r[0];
  endproperty
  a_trip_clear: assert property (p_trip_clear)
    else $error("trip bit survived clear");

  property p_unlevel_track;
    src_q[1] |=> cond_r[1] ##1 prev_r[1];
  endproperty
  a_unlevel_track: assert property (p_unlevel_track)
    else $error("unleveled bit not tracked");

  property p_drive_track;
    src_q[2] != $past(src_q[2]) |=> cond_r[2] == (HAS_MOD_DRIVE & $past(src_q[2]));
  endproperty
  a_drive_track: assert property (p_drive_track)
    else $error("drive excess bit wrong");

  property p_lowband_track;
    1'b1 |=> cond_r[3] == (HAS_LOWBAND & $past(src_q[3]));
  endproperty
  a_lowband_track: assert property (p_lowband_track)
    else $error("lowband bit wrong");

  property p_zero_bits;
    cond_r[15:4] == 12'h000 && rsp_data_r[15] == 1'b0 && event_r[15] == 1'b0;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("unused bit set");

  property p_removed;
    (!HAS_REV_POWER |-> !cond_r[0]) and (!HAS_MOD_DRIVE |-> !event_r[2]);
  endproperty
  a_removed: assert property (p_removed)
    else $error("removed source visible");

  property p_cond_read;
    rd && is_sel(cmd_sel, psg_pkg::SEL_COND) |=> rsp_valid_r && rsp_data_r == $past(cond_r);
  endproperty
  a_cond_read: assert property (p_cond_read)
    else $error("condition read mismatch");

  property p_edge_set;
    |set_vec |=> (event_r & $past(set_vec)) == $past(set_vec);
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("enabled edge not latched");

  property p_latch_hold;
    !latch_rd |=> (event_r & $past(event_r)) == $past(event_r);
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latch bit lost");

  property p_read_clear;
    latch_rd |=> rsp_data_r == $past(event_r) && (event_r & ~$past(set_vec)) == 16'h0000;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("latch read or clear wrong");

  property p_summary;
    |(event_r & mask_r) |=> power_summary_r;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary not raised");

  property p_mask_readback;
    mask_wr |=> mask_r == $past(mask_wdata);
  endproperty
  a_mask_readback: assert property (p_mask_readback)
    else $error("mask write not stored");

  property p_prev;
    1'b1 |=> prev_r == $past(cond_r);
  endproperty
  a_prev: assert property (p_prev)
    else $error("previous value not stored");

  property p_clear_race;
    latch_rd && |set_vec |=> (event_r & $past(set_vec)) != 16'h0000;
  endproperty
  a_clear_race: assert property (p_clear_race)
    else $error("edge lost in read-clear");

  property p_summary_low;
    !(|(event_r & mask_r)) |=> !power_summary_r;
  endproperty
  a_summary_low: assert property (p_summary_low)
    else $error("summary raised without enabled latch bit");

  property p_mask_query;
    rd && is_sel(cmd_sel, psg_pkg::SEL_MASK) |=> rsp_data_r == $past(mask_r);
  endproperty
  a_mask_query: assert property (p_mask_query)
    else $error("mask query mismatch");

  // mask_wdata is the stored form of any filter or mask write
  property p_rise_write;
    wr && is_sel(cmd_sel, psg_pkg::SEL_RISE) |=> rise_r == $past(mask_wdata);
  endproperty
  a_rise_write: assert property (p_rise_write)
    else $error("rise filter write not stored");

  property p_fall_write;
    wr && is_sel(cmd_sel, psg_pkg::SEL_FALL) |=> fall_r == $past(mask_wdata);
  endproperty
  a_fall_write: assert property (p_fall_write)
    else $error("fall filter write not stored");

  property p_query_pulse;
    1'b1 |=> rsp_valid_r == $past(rd);
  endproperty
  a_query_pulse: assert property (p_query_pulse)
    else $error("answer strobe does not follow query");

  property p_query_idle;
    !rd |=> rsp_data_r == 16'h0000;
  endproperty
  a_query_idle: assert property (p_query_idle)
    else $error("answer word not zero when idle");

  property p_latch_nowrite;
    wr && is_sel(cmd_sel, psg_pkg::SEL_LATCH) |=>
      event_r == ($past(event_r) | $past(set_vec));
  endproperty
  a_latch_nowrite: assert property (p_latch_nowrite)
    else $error("latch changed by a write");
endmodule // psg_power_status

/* dv/psg_power_status_tb.sv */
// self-checking bench for the power status group: command port, fault pins, summary
// assumes a 50 MHz clock, synchronous active-low reset, pin changes settle within 8 clocks
`timescale 1ns/1ps
module psg_power_status_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] pin = 4'h0;
  logic cmd_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [2:0] cmd_sel = 3'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;
  logic power_summary_r;
  logic [15:0] rsp_data2_r;
  int fails = 0;
  int n_checks = 0;

  always #10 clk = ~clk;

  psg_power_status u_psg_power_status (
    .clk(clk), .rst_n(rst_n),
    .reverse_power_trip_in(pin[0]), .unleveled_in(pin[1]),
    .modulator_drive_excess_in(pin[2]), .lowband_heater_fault_in(pin[3]),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r), .power_summary_r(power_summary_r)
  );

  // build with only the unleveled source kept; shares every input with the full one
  psg_power_status #(.HAS_REV_POWER(1'b0), .HAS_MOD_DRIVE(1'b0), .HAS_LOWBAND(1'b0))
  u_psg_power_status_bare (
    .clk(clk), .rst_n(rst_n),
    .reverse_power_trip_in(pin[0]), .unleveled_in(pin[1]),
    .modulator_drive_excess_in(pin[2]), .lowband_heater_fault_in(pin[3]),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_sel(cmd_sel), .cmd_wdata(cmd_wdata),
    .rsp_valid_r(), .rsp_data_r(rsp_data2_r), .power_summary_r()
  );

  task automatic wr(input logic [2:0] sel, input logic [15:0] data);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_sel <= sel;
    cmd_wdata <= data;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  // the bare build is compared only where its removed bits must read zero
  task automatic rd(input logic [2:0] sel, input logic [15:0] exp);
    logic [15:0] exp2;
    exp2 = exp & 16'h0002;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b0;
    cmd_sel <= sel;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    n_checks++;
    if (rsp_valid_r !== 1'b1 || rsp_data_r !== exp) begin
      fails++;
      $display("[ERR] %0t query %0d got %h expected %h", $time, sel, rsp_data_r, exp);
    end
    if (sel == psg_pkg::SEL_COND || sel == psg_pkg::SEL_LATCH) begin
      n_checks++;
      if (rsp_data2_r !== exp2) begin
        fails++;
        $display("[ERR] %0t bare build query %0d got %h", $time, sel, rsp_data2_r);
      end
    end
  endtask

  // pins pass a three-flop synchroniser plus latch and summary stages
  task automatic pins(input logic [3:0] v);
    @(posedge clk);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic chk_sum(input logic exp);
    #1;
    n_checks++;
    if (power_summary_r !== exp) begin
      fails++;
      $display("[ERR] %0t summary got %b expected %b", $time, power_summary_r, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(psg_pkg::SEL_RISE, 16'h7FFF);
    rd(psg_pkg::SEL_FALL, 16'h0000);
    rd(psg_pkg::SEL_MASK, 16'h0000);
    rd(psg_pkg::SEL_LATCH, 16'h0000);
    wr(psg_pkg::SEL_RISE, 16'hFFFF);
    rd(psg_pkg::SEL_RISE, 16'h7FFF);
    wr(psg_pkg::SEL_COND, 16'h000F);
    rd(psg_pkg::SEL_COND, 16'h0000);
    pins(4'hF);
    rd(psg_pkg::SEL_COND, 16'h000F);
    wr(psg_pkg::SEL_LATCH, 16'h0000);
    rd(psg_pkg::SEL_LATCH, 16'h000F);
    rd(psg_pkg::SEL_LATCH, 16'h0000);
    pins(4'h0);
    rd(psg_pkg::SEL_COND, 16'h0001);
    rd(psg_pkg::SEL_LATCH, 16'h0000);
    wr(psg_pkg::SEL_PROT_CLEAR, 16'h0001);
    repeat (8) @(posedge clk);
    rd(psg_pkg::SEL_COND, 16'h0000);
    wr(psg_pkg::SEL_RISE, 16'h0008);
    wr(psg_pkg::SEL_FALL, 16'h0002);
    rd(psg_pkg::SEL_FALL, 16'h0002);
    pins(4'h8);
    pins(4'h0);
    rd(psg_pkg::SEL_LATCH, 16'h0008);
    pins(4'h2);
    rd(psg_pkg::SEL_LATCH, 16'h0000);
    pins(4'h0);
    chk_sum(1'b0);
    wr(psg_pkg::SEL_MASK, 16'h0002);
    repeat (2) @(posedge clk);
    chk_sum(1'b1);
    rd(psg_pkg::SEL_MASK, 16'h0002);
    rd(psg_pkg::SEL_LATCH, 16'h0002);
    @(posedge clk);
    chk_sum(1'b0);
    // pin timed so the new edge meets the latch read-clear in the same cycle
    @(posedge clk);
    pin <= 4'h8;
    repeat (4) @(posedge clk);
    rd(psg_pkg::SEL_LATCH, 16'h0000);
    rd(psg_pkg::SEL_LATCH, 16'h0008);
    pins(4'h0);
    pins(4'h8);
    pins(4'h0);
    chk_sum(1'b0);
    tally_and_finish();
  end

  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // psg_power_status_tb
